/* pse_engine.sv */
// Three-channel PWM script engine with Wishbone register access
// Assumes i_slow_tick pulses once per 32.768 kHz slow clock period
// Function
// - Ramp steps by one, saturating at limits
// - Divider select chooses divide 16 or 512
// - Step period counts prescaled ticks per step
// - Ramp runs full step count despite saturation
// - Step time spans 0.49 ms to one second
// - All-zero word restarts at file start
// - Zero step period with other bits loads duty
// - Duty load copies low byte to duty register
// - Branch jumps to destination address
// - Zero repeat count loops until stop
// - Repeat count minus one gives repetitions
// - Destination above 59 performs no loop
// - End stops script and raises interrupt
// - Release bit tristates, else keeps driving
// - Stop during trigger wait suppresses end
// - Trigger takes sixteen slow clock cycles
// - Wait stalls until all selected triggers
// - Sent triggers latched until waited on
// - Wait mask bit per source channel
// - Send mask bit per destination channel
// - While running, output high when period count <= duty, else only at full duty
// - Period counter runs from ramp to end
// - Stop during ramp waits for ramp end
`timescale 1ns/1ps
`include "pse_params.svh"
module pse_engine (
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic i_ce,
	input wire logic i_slow_tick,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [5:2] i_wb_adr,
	input wire logic [3:0] i_wb_sel,
	input wire logic [31:0] i_wb_dat,
	output logic [31:0] o_wb_dat,
	output logic o_wb_ack,
	output logic [2:0] o_pwm,
	output logic [2:0] o_pwm_oe,
	output logic o_irq
);
	localparam int N = `PSE_CH_NUM;

	function automatic pse_pkg::pse_op_e decode(input pse_pkg::pse_word_t w);
		if (w == 16'h0000)
			decode = pse_pkg::PSE_OP_RESTART;
		else if (!w[15] && w[`PSE_RAMP_PER_HI:`PSE_RAMP_PER_LO] == 6'h00)
			decode = pse_pkg::PSE_OP_LOAD;
		else if (!w[15])
			decode = pse_pkg::PSE_OP_RAMP;
		else if (w[15:13] == 3'h5)
			decode = pse_pkg::PSE_OP_BRANCH;
		else if (w[15:12] == 4'hc)
			decode = pse_pkg::PSE_OP_END;
		else if (w[15:13] == 3'h7)
			decode = pse_pkg::PSE_OP_TRIG;
		else
			decode = pse_pkg::PSE_OP_BAD;
	endfunction

	// Command files, one per channel
	logic [15:0] file_mem [N][`PSE_FILE_DEPTH];
	logic [5:0] waddr_reg, waddr_next;
	logic [1:0] wchan_reg, wchan_next;
	logic [2:0] start_req, stop_req;
	logic [5:0] start_addr_reg, start_addr_next;
	logic [2:0] irq_reg, irq_next;
	logic ack_reg, ack_next;
	logic [31:0] rdat_reg, rdat_next;

	// Per channel state
	pse_pkg::pse_state_e st_reg [N], st_next [N];
	logic [5:0] pc_reg [N], pc_next [N];
	logic [7:0] duty_reg [N], duty_next [N];
	logic [7:0] per_reg [N], per_next [N];
	logic run_reg [N], run_next [N];
	logic oe_reg [N], oe_next [N];
	logic [9:0] pre_reg [N], pre_next [N];
	logic [5:0] tick_reg [N], tick_next [N];
	logic [6:0] steps_reg [N], steps_next [N];
	logic [5:0] loop_reg [N], loop_next [N];
	logic loop_act_reg [N], loop_act_next [N];
	logic [4:0] tcnt_reg [N], tcnt_next [N];
	logic [2:0] trig_reg [N], trig_next [N];
	logic stop_pend_reg [N], stop_pend_next [N];
	logic [15:0] cmd_reg [N], cmd_next [N];
	logic [2:0] send_vec [N];

	wire bus_req = i_wb_cyc && i_wb_stb && !ack_reg;
	wire bus_wr = bus_req && i_wb_we && i_wb_sel[0];

	// Bus decode: ctrl writes start/stop strobes, one cycle answer
	always_comb
	begin
		waddr_next = waddr_reg;
		wchan_next = wchan_reg;
		start_addr_next = start_addr_reg;
		ack_next = bus_req;
		rdat_next = rdat_reg;
		start_req = 3'h0;
		stop_req = 3'h0;
		if (bus_wr && i_wb_adr == `PSE_ADR_WADDR)
		begin
			waddr_next = i_wb_dat[5:0];
			wchan_next = i_wb_dat[9:8];
		end
		if (bus_wr && i_wb_adr == `PSE_ADR_CTRL)
		begin
			start_req = i_wb_dat[2:0];
			stop_req = i_wb_dat[6:4];
			start_addr_next = i_wb_dat[13:8];
		end
		if (bus_req && !i_wb_we)
		begin
			case (i_wb_adr)
				`PSE_ADR_STAT:
					rdat_next = {22'h0, oe_reg[2], oe_reg[1], oe_reg[0],
						run_reg[2], run_reg[1], run_reg[0],
						1'b0, irq_reg};
				`PSE_ADR_WADDR:
					rdat_next = {22'h0, wchan_reg, 2'h0, waddr_reg};
				`PSE_ADR_WDATA:
					// Channel index 3 has no file; read it as zero
					rdat_next = (wchan_reg < 2'h3) ? {16'h0,
						file_mem[wchan_reg][waddr_reg]} : 32'h0;
				`PSE_ADR_DUTY:
					rdat_next = {8'h0, duty_reg[2], duty_reg[1],
						duty_reg[0]};
				default:
					rdat_next = 32'h0;
			endcase
		end
	end

	// Interrupt sticky bits: set wins over write-one-to-clear
	always_comb
	begin
		irq_next = irq_reg;
		if (bus_wr && i_wb_adr == `PSE_ADR_STAT)
			irq_next = irq_reg & ~i_wb_dat[2:0];
		for (int c = 0; c < N; c++)
			if (st_reg[c] == pse_pkg::PSE_ST_DONE)
				irq_next[c] = 1'b1;
	end

	// Triggers sent by every channel this cycle, per destination
	always_comb
	begin
		for (int d = 0; d < N; d++)
		begin
			send_vec[d] = 3'h0;
			for (int s = 0; s < N; s++)
				if (st_reg[s] == pse_pkg::PSE_ST_TRIG
					&& tcnt_reg[s] == 5'h01 && i_slow_tick
					&& cmd_reg[s][`PSE_TRG_SEND_LO + d])
					send_vec[d][s] = 1'b1;
		end
	end

	always_comb
	begin
		for (int c = 0; c < N; c++)
		begin
			logic [15:0] w;
			logic [5:0] waitm;
			logic slow_now;
			w = file_mem[c][pc_reg[c]];
			waitm = cmd_reg[c][`PSE_TRG_WAIT_HI:`PSE_TRG_WAIT_LO];
			slow_now = 1'b0;
			st_next[c] = st_reg[c];
			pc_next[c] = pc_reg[c];
			duty_next[c] = duty_reg[c];
			per_next[c] = per_reg[c];
			run_next[c] = run_reg[c];
			oe_next[c] = oe_reg[c];
			pre_next[c] = pre_reg[c];
			tick_next[c] = tick_reg[c];
			steps_next[c] = steps_reg[c];
			loop_next[c] = loop_reg[c];
			loop_act_next[c] = loop_act_reg[c];
			tcnt_next[c] = tcnt_reg[c];
			cmd_next[c] = cmd_reg[c];
			stop_pend_next[c] = stop_pend_reg[c] | stop_req[c];
			trig_next[c] = trig_reg[c] | send_vec[c];
			if (run_reg[c])
				per_next[c] = per_reg[c] + 8'h01;
			case (st_reg[c])
				pse_pkg::PSE_ST_IDLE:
				begin
					stop_pend_next[c] = 1'b0;
					if (start_req[c])
					begin
						pc_next[c] = start_addr_reg;
						loop_act_next[c] = 1'b0;
						oe_next[c] = 1'b1;
						st_next[c] = pse_pkg::PSE_ST_FETCH;
					end
				end
				pse_pkg::PSE_ST_FETCH:
				begin
					cmd_next[c] = w;
					pc_next[c] = pc_reg[c] + 6'h01;
					if (stop_pend_reg[c] || stop_req[c])
						st_next[c] = pse_pkg::PSE_ST_IDLE;
					else
						case (decode(w))
							pse_pkg::PSE_OP_RESTART:
								pc_next[c] = 6'h00;
							pse_pkg::PSE_OP_LOAD:
								duty_next[c] = w[7:0];
							pse_pkg::PSE_OP_RAMP:
							begin
								steps_next[c] = w[`PSE_RAMP_CNT_HI:0];
								tick_next[c] = 6'h00;
								pre_next[c] = 10'h000;
								if (!run_reg[c])
									per_next[c] = 8'h00;
								run_next[c] = 1'b1;
								if (w[`PSE_RAMP_CNT_HI:0] != 7'h00)
									st_next[c] = pse_pkg::PSE_ST_RAMP;
							end
							pse_pkg::PSE_OP_BRANCH:
							begin
								if (w[`PSE_BR_ADDR_HI:0] > `PSE_LAST_ADDR)
									pc_next[c] = pc_reg[c] + 6'h01;
								else if (w[`PSE_BR_REP_HI:`PSE_BR_REP_LO]
									== 6'h00)
									pc_next[c] = w[`PSE_BR_ADDR_HI:0];
								else if (!loop_act_reg[c])
								begin
									// Count minus one remaining passes
									loop_next[c] =
										w[`PSE_BR_REP_HI:`PSE_BR_REP_LO]
										- 6'h01;
									loop_act_next[c] =
										w[`PSE_BR_REP_HI:`PSE_BR_REP_LO]
										!= 6'h01;
									if (w[`PSE_BR_REP_HI:`PSE_BR_REP_LO]
										!= 6'h01)
										pc_next[c] = w[`PSE_BR_ADDR_HI:0];
								end
								else if (loop_reg[c] > 6'h01)
								begin
									loop_next[c] = loop_reg[c] - 6'h01;
									pc_next[c] = w[`PSE_BR_ADDR_HI:0];
								end
								else
									loop_act_next[c] = 1'b0;
							end
							pse_pkg::PSE_OP_END:
							begin
								run_next[c] = 1'b0;
								oe_next[c] = !w[`PSE_END_REL_BIT];
								st_next[c] = pse_pkg::PSE_ST_DONE;
							end
							pse_pkg::PSE_OP_TRIG:
							begin
								tcnt_next[c] = `PSE_TRIG_TICKS;
								st_next[c] = pse_pkg::PSE_ST_TRIG;
							end
							default:
								st_next[c] = pse_pkg::PSE_ST_FETCH;
						endcase
				end
				pse_pkg::PSE_ST_RAMP:
				if (i_slow_tick)
				begin
					// Divider select picks 16 or 512
					if (pre_reg[c] == (cmd_reg[c][`PSE_RAMP_DIV_BIT]
						? `PSE_DIV_SLOW : `PSE_DIV_FAST))
					begin
						pre_next[c] = 10'h000;
						slow_now = 1'b1;
					end
					else
						pre_next[c] = pre_reg[c] + 10'h001;
					if (slow_now)
					begin
						if (tick_reg[c] + 6'h01 ==
							cmd_reg[c][`PSE_RAMP_PER_HI:`PSE_RAMP_PER_LO])
						begin
							tick_next[c] = 6'h00;
							if (!cmd_reg[c][`PSE_RAMP_DIR_BIT])
							begin
								if (duty_reg[c] != `PSE_DUTY_MAX)
									duty_next[c] = duty_reg[c] + 8'h01;
							end
							else if (duty_reg[c] != `PSE_DUTY_MIN)
								duty_next[c] = duty_reg[c] - 8'h01;
							steps_next[c] = steps_reg[c] - 7'h01;
							if (steps_reg[c] == 7'h01)
								st_next[c] = pse_pkg::PSE_ST_FETCH;
						end
						else
							tick_next[c] = tick_reg[c] + 6'h01;
					end
				end
				pse_pkg::PSE_ST_TRIG:
				begin
					if (i_slow_tick && tcnt_reg[c] != 5'h00)
						tcnt_next[c] = tcnt_reg[c] - 5'h01;
					if (stop_pend_reg[c] || stop_req[c])
						st_next[c] = pse_pkg::PSE_ST_IDLE;
					else if (tcnt_reg[c] == 5'h00
						&& (trig_reg[c] & waitm[2:0]) == waitm[2:0])
					begin
						trig_next[c] = (trig_reg[c] & ~waitm[2:0])
							| send_vec[c];
						st_next[c] = pse_pkg::PSE_ST_FETCH;
					end
				end
				pse_pkg::PSE_ST_DONE:
					st_next[c] = pse_pkg::PSE_ST_IDLE;
				default:
					st_next[c] = pse_pkg::PSE_ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_reset_n)
		begin
			waddr_reg <= 6'h00;
			wchan_reg <= 2'h0;
			start_addr_reg <= 6'h00;
			irq_reg <= 3'h0;
			ack_reg <= 1'b0;
			rdat_reg <= 32'h0;
			for (int c = 0; c < N; c++)
			begin
				st_reg[c] <= pse_pkg::PSE_ST_IDLE;
				pc_reg[c] <= 6'h00;
				duty_reg[c] <= 8'h00;
				per_reg[c] <= 8'h00;
				run_reg[c] <= 1'b0;
				oe_reg[c] <= 1'b0;
				pre_reg[c] <= 10'h000;
				tick_reg[c] <= 6'h00;
				steps_reg[c] <= 7'h00;
				loop_reg[c] <= 6'h00;
				loop_act_reg[c] <= 1'b0;
				tcnt_reg[c] <= 5'h00;
				trig_reg[c] <= 3'h0;
				stop_pend_reg[c] <= 1'b0;
				cmd_reg[c] <= 16'h0000;
			end
		end
		else if (i_ce)
		begin
			waddr_reg <= waddr_next;
			wchan_reg <= wchan_next;
			start_addr_reg <= start_addr_next;
			irq_reg <= irq_next;
			ack_reg <= ack_next;
			rdat_reg <= rdat_next;
			for (int c = 0; c < N; c++)
			begin
				st_reg[c] <= st_next[c];
				pc_reg[c] <= pc_next[c];
				duty_reg[c] <= duty_next[c];
				per_reg[c] <= per_next[c];
				run_reg[c] <= run_next[c];
				oe_reg[c] <= oe_next[c];
				pre_reg[c] <= pre_next[c];
				tick_reg[c] <= tick_next[c];
				steps_reg[c] <= steps_next[c];
				loop_reg[c] <= loop_next[c];
				loop_act_reg[c] <= loop_act_next[c];
				tcnt_reg[c] <= tcnt_next[c];
				trig_reg[c] <= trig_next[c];
				stop_pend_reg[c] <= stop_pend_next[c];
				cmd_reg[c] <= cmd_next[c];
			end
		end
	end

	// File memory has no reset; contents belong to the host
	always_ff @(posedge i_clk)
	begin
		if (i_ce && bus_wr && i_wb_adr == `PSE_ADR_WDATA && wchan_reg < 2'h3)
			file_mem[wchan_reg][waddr_reg] <= i_wb_dat[15:0];
	end

	// Output drive: registered compare result
	logic [2:0] pwm_reg;
	always_ff @(posedge i_clk)
	begin
		if (!i_reset_n)
			pwm_reg <= 3'h0;
		else if (i_ce)
			for (int c = 0; c < N; c++)
				pwm_reg[c] <= run_next[c] ? (per_next[c] <= duty_next[c])
					: (duty_next[c] == `PSE_DUTY_MAX);
	end

	assign o_pwm = pwm_reg;
	assign o_pwm_oe = {oe_reg[2], oe_reg[1], oe_reg[0]};
	assign o_irq = |irq_reg;
	assign o_wb_ack = ack_reg;
	assign o_wb_dat = rdat_reg;
endmodule

/* pse_params.svh */
// Constants for the PWM script engine: field positions, timing counts
// Assumes a 250 MHz system clock and a 32.768 kHz slow clock strobe input
`ifndef PSE_PARAMS_SVH
`define PSE_PARAMS_SVH
`define PSE_CH_NUM 3
`define PSE_FILE_DEPTH 64
`define PSE_ADDR_W 6
`define PSE_LAST_ADDR 6'h3b
`define PSE_DIV_FAST 10'h00f
`define PSE_DIV_SLOW 10'h1ff
`define PSE_TRIG_TICKS 5'h10
`define PSE_STEP_MS_MIN_X100 49
`define PSE_DUTY_MAX 8'hff
`define PSE_DUTY_MIN 8'h00
`define PSE_RAMP_DIV_BIT 14
`define PSE_RAMP_PER_HI 13
`define PSE_RAMP_PER_LO 8
`define PSE_RAMP_DIR_BIT 7
`define PSE_RAMP_CNT_HI 6
`define PSE_BR_REP_HI 12
`define PSE_BR_REP_LO 7
`define PSE_BR_ADDR_HI 5
`define PSE_TRG_WAIT_HI 12
`define PSE_TRG_WAIT_LO 7
`define PSE_TRG_SEND_HI 6
`define PSE_TRG_SEND_LO 1
`define PSE_END_REL_BIT 11
`define PSE_ADR_CTRL 4'h0
`define PSE_ADR_STAT 4'h1
`define PSE_ADR_WADDR 4'h2
`define PSE_ADR_WDATA 4'h3
`define PSE_ADR_DUTY 4'h4
`endif

/* pse_pkg.sv */
// Types shared by the PWM script engine
// Assumes pse_params.svh is compiled alongside
package pse_pkg;
	typedef enum logic [2:0] {
		PSE_ST_IDLE,
		PSE_ST_FETCH,
		PSE_ST_RAMP,
		PSE_ST_TRIG,
		PSE_ST_DONE
	} pse_state_e;
	typedef enum logic [2:0] {
		PSE_OP_RESTART,
		PSE_OP_LOAD,
		PSE_OP_RAMP,
		PSE_OP_BRANCH,
		PSE_OP_END,
		PSE_OP_TRIG,
		PSE_OP_BAD
	} pse_op_e;
	typedef struct packed {
		logic [7:0] duty;
		logic run;
		logic drive;
		logic done;
	} pse_chan_s;
	typedef logic [15:0] pse_word_t;
endpackage

/* pse_engine_asserts.sv */
// Bus and output checks for the PWM script engine
// Assumes binding to pse_engine, with i_ce held high by the bench
`timescale 1ns/1ps
module pse_engine_asserts (
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic i_ce,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [5:2] i_wb_adr,
	input wire logic [31:0] o_wb_dat,
	input wire logic o_wb_ack,
	input wire logic [2:0] o_pwm,
	input wire logic [2:0] o_pwm_oe,
	input wire logic o_irq
);
	default clocking cb @(posedge i_clk);
	endclocking
	property p_ack_next;
		disable iff (!i_reset_n)
		i_ce && i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack;
	endproperty
	a_ack_next: assert property (p_ack_next)
		else $error("ack missing after request");
	property p_ack_pulse;
		disable iff (!i_reset_n)
		o_wb_ack |=> !o_wb_ack;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse)
		else $error("ack longer than one cycle");
	property p_ack_cause;
		disable iff (!i_reset_n)
		o_wb_ack |-> $past(i_wb_cyc && i_wb_stb);
	endproperty
	a_ack_cause: assert property (p_ack_cause)
		else $error("ack without request");
	property p_reset_quiet;
		!i_reset_n |=> o_irq == 1'b0 && o_pwm_oe == 3'h0 && o_pwm == 3'h0;
	endproperty
	a_reset_quiet: assert property (p_reset_quiet)
		else $error("outputs active after reset");
	property p_irq_hold;
		disable iff (!i_reset_n)
		o_irq && !(i_wb_cyc && i_wb_we) |=> o_irq;
	endproperty
	a_irq_hold: assert property (p_irq_hold)
		else $error("interrupt dropped without clear");
	property p_irq_clear;
		disable iff (!i_reset_n)
		$fell(o_irq) |-> $past(i_wb_cyc && i_wb_we && i_wb_adr == 4'h1);
	endproperty
	a_irq_clear: assert property (p_irq_clear)
		else $error("interrupt fell without status write");
	property p_oe_release;
		disable iff (!i_reset_n)
		|($past(o_pwm_oe) & ~o_pwm_oe) |-> ##[0:2] o_irq;
	endproperty
	a_oe_release: assert property (p_oe_release)
		else $error("output released without end");
	property p_unmapped;
		disable iff (!i_reset_n)
		o_wb_ack && !i_wb_we && i_wb_adr > 4'h4 |-> o_wb_dat == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped read not zero");
endmodule

/* pse_host_model.sv */
// Host side bus master issuing classic Wishbone single cycles
// Assumes the slave acks within the bench timeout
`timescale 1ns/1ps
module pse_host_model (
	input wire logic i_clk,
	input wire logic i_ack,
	output logic o_cyc,
	output logic o_stb,
	output logic o_we,
	output logic [3:0] o_adr,
	output logic [3:0] o_sel,
	output logic [31:0] o_dat
);
	initial
	begin
		o_cyc = 1'b0;
		o_stb = 1'b0;
		o_we = 1'b0;
		o_adr = 4'h0;
		o_sel = 4'h0;
		o_dat = 32'h0;
	end
	// One request at a time, held until ack is sampled
	task automatic xfer(input logic we, input logic [3:0] adr,
		input logic [31:0] dat);
		@(posedge i_clk);
		o_cyc <= 1'b1;
		o_stb <= 1'b1;
		o_we <= we;
		o_adr <= adr;
		o_sel <= 4'hf;
		o_dat <= dat;
		@(posedge i_clk);
		while (i_ack !== 1'b1)
			@(posedge i_clk);
		o_cyc <= 1'b0;
		o_stb <= 1'b0;
		o_we <= 1'b0;
		// Released lines must not look like a held request
		o_adr <= ~adr;
		o_dat <= ~dat;
	endtask
endmodule

/* pse_engine_bench.sv */
// Self-checking bench for the PWM script engine
// Assumes a slow tick every two clocks, so one step is 32 clocks
`timescale 1ns/1ps
module pse_engine_bench;
	typedef struct packed {
		logic [31:0] dat;
		logic [31:0] mask;
	} pse_note_s;
	logic i_clk = 1'b0;
	logic i_reset_n = 1'b0;
	logic i_slow_tick = 1'b0;
	logic cyc, stb, we, ack, irq;
	logic [3:0] adr, sel;
	logic [31:0] wdat, rdat;
	logic [2:0] pwm, oe;
	int n_errors = 0;
	int samples_checked = 0;
	int cycles = 0;
	int r;
	pse_note_s notes[$];
	always #2 i_clk = ~i_clk;
	always @(posedge i_clk)
		i_slow_tick <= ~i_slow_tick;
	pse_engine u_dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_ce(1'b1),
		.i_slow_tick(i_slow_tick), .i_wb_cyc(cyc), .i_wb_stb(stb),
		.i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat),
		.o_wb_dat(rdat), .o_wb_ack(ack), .o_pwm(pwm), .o_pwm_oe(oe),
		.o_irq(irq));
	pse_host_model u_host (.i_clk(i_clk), .i_ack(ack), .o_cyc(cyc),
		.o_stb(stb), .o_we(we), .o_adr(adr), .o_sel(sel), .o_dat(wdat));
	task automatic err(input string msg);
		n_errors++;
		$display("Error at %0t: %s", $time, msg);
	endtask
	task automatic finish_test;
		if (n_errors == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic check_read(input pse_note_s n, input logic [31:0] got);
		samples_checked++;
		if ((got & n.mask) !== (n.dat & n.mask))
			err("read data mismatch");
	endtask
	task automatic check_bit(input logic got, input logic exp);
		samples_checked++;
		if (got !== exp)
			err("output level mismatch");
	endtask
	always @(posedge i_clk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			err("timeout");
			finish_test;
		end
		if (ack === 1'b1 && we === 1'b0)
		begin
			if (notes.size() == 0)
				err("unexpected read");
			else
				check_read(notes.pop_front(), rdat);
		end
	end
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		u_host.xfer(1'b1, a, d);
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] e,
		input logic [31:0] m);
		notes.push_back({e, m});
		u_host.xfer(1'b0, a, 32'h0);
	endtask
	task automatic load(input logic [1:0] ch, input logic [5:0] a,
		input logic [15:0] w);
		wr(4'h2, {22'h0, ch, 2'h0, a});
		wr(4'h3, {16'h0, w});
	endtask
	task automatic wait_irq(input int lim);
		for (int i = 0; i < lim && irq !== 1'b1; i++)
			@(posedge i_clk);
		if (irq !== 1'b1)
			err("interrupt missing");
	endtask
	initial
	begin
		void'($urandom(25));
		repeat (10) @(posedge i_clk);
		i_reset_n <= 1'b1;
		rd(4'h1, 32'h0, 32'hffff_ffff);
		rd(4'h7, 32'h0, 32'hffff_ffff);
		load(2'h1, 6'h00, 16'h40ff);
		load(2'h1, 6'h01, 16'h0102);
		load(2'h1, 6'h02, 16'hc800);
		rd(4'h2, 32'h0000_0102, 32'h0000_03ff);
		wr(4'h0, 32'h2);
		repeat (60) @(posedge i_clk);
		check_bit(irq, 1'b0);
		wait_irq(40);
		rd(4'h4, 32'h0000_ff00, 32'h0000_ff00);
		check_bit(oe[1], 1'b0);
		check_bit(pwm[1], 1'b1);
		rd(4'h1, 32'h2, 32'h7);
		wr(4'h1, 32'h7);
		repeat (2) @(posedge i_clk);
		check_bit(irq, 1'b0);
		// Repeat count chosen at random, 1 means a single pass
		r = $urandom_range(4, 1);
		load(2'h0, 6'h00, 16'h4000);
		load(2'h0, 6'h01, 16'he200);
		load(2'h0, 6'h02, 16'h0101);
		load(2'h0, 6'h03, 16'ha002 | (16'(r) << 7));
		load(2'h0, 6'h04, 16'hc000);
		load(2'h2, 6'h00, 16'he002);
		load(2'h2, 6'h01, 16'hc000);
		wr(4'h0, 32'h1);
		repeat (200) @(posedge i_clk);
		check_bit(irq, 1'b0);
		rd(4'h4, 32'h0, 32'hff);
		wr(4'h0, 32'h4);
		repeat (28) @(posedge i_clk);
		check_bit(irq, 1'b0);
		wait_irq(30);
		rd(4'h1, 32'h4, 32'h7);
		wr(4'h1, 32'h4);
		repeat (2) @(posedge i_clk);
		wait_irq(200);
		rd(4'h4, 32'(r), 32'hff);
		check_bit(oe[0], 1'b1);
		check_bit(pwm[0], 1'b0);
		rd(4'h1, 32'h1, 32'h7);
		finish_test;
	end
endmodule
bind pse_engine pse_engine_asserts u_chk (.i_clk(i_clk),
	.i_reset_n(i_reset_n), .i_ce(i_ce), .i_wb_cyc(i_wb_cyc),
	.i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr),
	.o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .o_pwm(o_pwm),
	.o_pwm_oe(o_pwm_oe), .o_irq(o_irq));
